// *** rtl/eirq_ctrl.sv ***
// Interrupt request controller driving the endpoint interrupt port
// Notes on behaviour
// - Legacy raise drives request high with raise select high, line on vector.
// - Device pulses accept on legacy raise; request drops the next cycle.
// - Withdrawal drives request with raise select low and the same line.
// - Device accepts withdrawal, sends line-A deassert; request drops next cycle.
// - Legacy vector 00h is line A; other values unsupported, only 00h sent.
// - MSI raises request with vector number when multi-vector enabled.
// - Device accepts MSI, sends one write; request drops next cycle.
// - Vector is zero-padded above the vector number; 000b means zero.
// - With per-vector masking, never signal a masked vector.
// - In MSI-X mode messages go on the transmit stream, not here.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
module eirq_ctrl (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq_req,
	output logic irq_assert_sel,
	output logic [7:0] irq_vector_in,
	input wire logic irq_accept,
	input wire logic msi_mode,
	input wire logic msix_mode,
	input wire logic [2:0] mm_enable,
	input wire logic intr_disable
);
	eirq_pkg::eirq_state_e state_reg;
	eirq_pkg::eirq_state_e state_next;
	logic req_reg;
	logic req_next;
	logic sel_reg;
	logic sel_next;
	logic [7:0] vec_reg;
	logic [7:0] vec_next;
	logic legacy_reg;
	logic legacy_next;
	logic [2:0] bits_reg;
	logic [2:0] bits_next;
	logic raised_reg;
	logic raised_next;
	logic refused_reg;
	logic refused_next;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [31:0] mask_reg;
	logic [31:0] mask_next;
	logic [31:0] rd_data;
	logic wr_stb;
	logic [7:0] fmt_vec;
	logic [2:0] fmt_bits;
	logic cmd_wr;
	logic cmd_masked;
	logic cmd_ok;
	logic [31:0] cmd_word;

	// ==========================================
	// Bus front end and vector formatting
	eirq_avs u_avs (
		.mclk(mclk),
		.rstn(rstn),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.rd_data(rd_data),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.wr_stb(wr_stb)
	);

	assign cmd_word = eirq_pkg::eirq_be_merge(32'h0000_0000, avs_writedata,
		avs_byteenable);

	eirq_vec_fmt u_fmt (
		.msi_mode(msi_mode),
		.mm_enable(mm_enable),
		.raw_vec(cmd_word[eirq_pkg::CMD_VEC_LSB +: 8]),
		.vec(fmt_vec),
		.bits(fmt_bits)
	);

	// ==========================================
	// Read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		if (avs_address == eirq_pkg::CMD_OFS) begin
			rd_data[eirq_pkg::CMD_VEC_LSB +: 8] = vec_reg;
			rd_data[eirq_pkg::CMD_RAISE_BIT] = sel_reg;
		end else if (avs_address == eirq_pkg::STATUS_OFS) begin
			rd_data[eirq_pkg::ST_BUSY_BIT] = (state_reg != eirq_pkg::EIRQ_IDLE);
			rd_data[eirq_pkg::ST_RAISED_BIT] = raised_reg;
			rd_data[eirq_pkg::ST_REFUSED_BIT] = refused_reg;
			rd_data[eirq_pkg::ST_MSI_BIT] = msi_mode;
			rd_data[eirq_pkg::ST_MSIX_BIT] = msix_mode;
			rd_data[eirq_pkg::ST_INTDIS_BIT] = intr_disable;
			rd_data[eirq_pkg::ST_MMEN_LSB +: 3] = mm_enable;
		end else if (avs_address == eirq_pkg::COUNT_OFS) begin
			rd_data[15:0] = count_reg;
		end else if (avs_address == eirq_pkg::MASK_OFS) begin
			rd_data = mask_reg;
		end
	end

	// ==========================================
	// Request sequencer
	always_comb begin
		cmd_wr = wr_stb && (avs_address == eirq_pkg::CMD_OFS);
		cmd_masked = msi_mode && mask_reg[fmt_vec[4:0]];
		cmd_ok = (state_reg == eirq_pkg::EIRQ_IDLE) && !msix_mode
			&& !cmd_masked;
		state_next = state_reg;
		req_next = req_reg;
		sel_next = sel_reg;
		vec_next = vec_reg;
		legacy_next = legacy_reg;
		bits_next = bits_reg;
		raised_next = raised_reg;
		count_next = count_reg;
		refused_next = refused_reg;
		mask_next = mask_reg;
		if (wr_stb && (avs_address == eirq_pkg::STATUS_OFS)
			&& avs_byteenable[0] && avs_writedata[eirq_pkg::ST_REFUSED_BIT]) begin
			refused_next = 1'b0;
		end
		if (wr_stb && (avs_address == eirq_pkg::MASK_OFS)) begin
			mask_next = eirq_pkg::eirq_be_merge(mask_reg, avs_writedata,
				avs_byteenable);
		end
		case (state_reg)
			eirq_pkg::EIRQ_IDLE: begin
				if (cmd_wr && cmd_ok) begin
					state_next = eirq_pkg::EIRQ_WAIT;
					req_next = 1'b1;
					sel_next = !msi_mode
						&& cmd_word[eirq_pkg::CMD_RAISE_BIT];
					vec_next = fmt_vec;
					legacy_next = !msi_mode;
					bits_next = fmt_bits;
				end
			end
			eirq_pkg::EIRQ_WAIT: begin
				if (irq_accept) begin
					state_next = eirq_pkg::EIRQ_IDLE;
					req_next = 1'b0;
					count_next = count_reg + 16'h0001;
					if (legacy_reg) begin
						raised_next = sel_reg;
					end
				end
			end
			default: begin
				state_next = eirq_pkg::EIRQ_IDLE;
			end
		endcase
		if (cmd_wr && !cmd_ok) begin
			refused_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_reg <= eirq_pkg::EIRQ_IDLE;
			req_reg <= 1'b0;
			sel_reg <= 1'b0;
			vec_reg <= eirq_pkg::LINE_A_VEC;
			legacy_reg <= 1'b1;
			bits_reg <= 3'h0;
			raised_reg <= 1'b0;
			refused_reg <= 1'b0;
			count_reg <= eirq_pkg::COUNT_RESET;
			mask_reg <= eirq_pkg::MASK_RESET;
		end else begin
			state_reg <= state_next;
			req_reg <= req_next;
			sel_reg <= sel_next;
			vec_reg <= vec_next;
			legacy_reg <= legacy_next;
			bits_reg <= bits_next;
			raised_reg <= raised_next;
			refused_reg <= refused_next;
			count_reg <= count_next;
			mask_reg <= mask_next;
		end
	end

	assign irq_req = req_reg;
	assign irq_assert_sel = sel_reg;
	assign irq_vector_in = vec_reg;

	// ==========================================
	// Checks
	AST_RAISE_HOLD: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_req && !irq_accept |=> irq_req && $stable(irq_vector_in)
			&& $stable(irq_assert_sel))
		else $error("request changed before accept");
	AST_RAISE_DROP: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_accept && irq_req && irq_assert_sel |=> !irq_req)
		else $error("raise request not dropped");
	AST_WITHDRAW_LINE: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_req && legacy_reg && !irq_assert_sel |-> irq_vector_in == 8'h00)
		else $error("withdrawal on wrong line");
	AST_WITHDRAW_DROP: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_accept && irq_req && !irq_assert_sel |=> !irq_req)
		else $error("withdraw request not dropped");
	AST_LEGACY_VEC: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_req && legacy_reg |-> irq_vector_in == 8'h00)
		else $error("legacy vector not line A");
	AST_MSI_DROP: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_accept && irq_req && !legacy_reg |=>
			!irq_req && state_reg == eirq_pkg::EIRQ_IDLE)
		else $error("MSI request not dropped");
	AST_MSI_PAD: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_req && !legacy_reg |->
			(irq_vector_in & ~eirq_pkg::eirq_low_mask(bits_reg)) == 8'h00)
		else $error("vector not zero padded");
	AST_MSI_MASK: assert property (@(posedge mclk)
		disable iff (!rstn)
		$rose(irq_req) |-> !$past(cmd_masked))
		else $error("masked vector signalled");
	AST_MSIX_QUIET: assert property (@(posedge mclk)
		disable iff (!rstn)
		$rose(irq_req) |-> !$past(msix_mode))
		else $error("request raised in MSI-X mode");
	AST_ONE_ACCEPT: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_accept && state_reg == eirq_pkg::EIRQ_WAIT |=>
			state_reg == eirq_pkg::EIRQ_IDLE && !irq_req)
		else $error("accept not closing request");
	AST_MSI_SEL_LOW: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_req && !legacy_reg |-> !irq_assert_sel)
		else $error("select raised in MSI mode");
	AST_IDLE_QUIET: assert property (@(posedge mclk)
		disable iff (!rstn)
		state_reg == eirq_pkg::EIRQ_IDLE |-> !irq_req)
		else $error("request high while idle");
	AST_WAIT_HELD: assert property (@(posedge mclk)
		disable iff (!rstn)
		state_reg == eirq_pkg::EIRQ_WAIT |-> irq_req)
		else $error("request low while waiting");
	AST_COUNT_STEP: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_accept && irq_req |=>
			count_reg == $past(count_reg) + 16'h0001)
		else $error("accept not counted");
	AST_COUNT_HOLD: assert property (@(posedge mclk)
		disable iff (!rstn)
		!(irq_accept && irq_req) |=> $stable(count_reg))
		else $error("count moved without accept");
	AST_TAKE_VEC: assert property (@(posedge mclk)
		disable iff (!rstn)
		$rose(irq_req) |-> irq_vector_in == $past(fmt_vec))
		else $error("vector not the formatted one");
	AST_TAKE_ONLY: assert property (@(posedge mclk)
		disable iff (!rstn)
		$rose(irq_req) |-> $past(cmd_wr) && $past(cmd_ok))
		else $error("request raised without command");
	AST_REFUSE_FLAG: assert property (@(posedge mclk)
		disable iff (!rstn)
		cmd_wr && !cmd_ok |=> refused_reg)
		else $error("refused command not flagged");
	AST_REFUSE_QUIET: assert property (@(posedge mclk)
		disable iff (!rstn)
		cmd_wr && !cmd_ok && !irq_req |=> !irq_req)
		else $error("refused command raised request");
	AST_LEGACY_RAISED: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_accept && irq_req && legacy_reg |=>
			raised_reg == $past(irq_assert_sel))
		else $error("raised flag not following accept");
	AST_MSI_RAISED: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_accept && irq_req && !legacy_reg |=> $stable(raised_reg))
		else $error("raised flag moved by MSI");
	AST_MODE_LATCH: assert property (@(posedge mclk)
		disable iff (!rstn)
		$rose(irq_req) |-> legacy_reg == !$past(msi_mode))
		else $error("mode not latched at command");
	AST_MSI_WIDTH: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_req && !legacy_reg |-> bits_reg <= eirq_pkg::MM_CAPABLE)
		else $error("vector width above capability");
	AST_SINGLE_VEC: assert property (@(posedge mclk)
		disable iff (!rstn)
		irq_req && !legacy_reg && bits_reg == 3'h0 |->
			irq_vector_in == 8'h00)
		else $error("single vector not zero");
endmodule

// *** rtl/eirq_pkg.sv ***
// Package of constants and helpers for the interrupt request controller
package eirq_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [3:0] CMD_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] COUNT_OFS = 4'h8;
	localparam logic [3:0] MASK_OFS = 4'hC;
	// ==========================================
	// Command fields
	localparam int CMD_VEC_LSB = 0;
	localparam int CMD_RAISE_BIT = 8;
	// ==========================================
	// Status fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_RAISED_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_MSI_BIT = 3;
	localparam int ST_MSIX_BIT = 4;
	localparam int ST_INTDIS_BIT = 5;
	localparam int ST_MMEN_LSB = 8;
	// ==========================================
	// Reset values and build settings
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] LINE_A_VEC = 8'h00;
	localparam logic [2:0] MM_CAPABLE = 3'h5;
	localparam logic [2:0] MM_MAX = 3'h5;

	typedef enum {EIRQ_IDLE, EIRQ_WAIT} eirq_state_e;

	// Number of overridable vector bits
	function automatic logic [2:0] eirq_vec_bits(input logic [2:0] mmen);
		logic [2:0] b;
		b = (mmen < MM_CAPABLE) ? mmen : MM_CAPABLE;
		if (b > MM_MAX) begin
			b = MM_MAX;
		end
		return b;
	endfunction

	// Mask of the low vector bits
	function automatic logic [7:0] eirq_low_mask(input logic [2:0] bits);
		logic [8:0] m;
		m = (9'h001 << bits) - 9'h001;
		return m[7:0];
	endfunction

	// Byte-enable merge of a register word
	function automatic logic [31:0] eirq_be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

// *** rtl/eirq_vec_fmt.sv ***
// Vector formatting for legacy and MSI requests
`timescale 1ns/10ps
module eirq_vec_fmt (
	input wire logic msi_mode,
	input wire logic [2:0] mm_enable,
	input wire logic [7:0] raw_vec,
	output logic [7:0] vec,
	output logic [2:0] bits
);
	// ==========================================
	// Legacy forces line A, MSI pads with zeros
	always_comb begin
		bits = 3'h0;
		if (!msi_mode) begin
			vec = eirq_pkg::LINE_A_VEC;
		end else begin
			bits = eirq_pkg::eirq_vec_bits(mm_enable);
			vec = raw_vec & eirq_pkg::eirq_low_mask(bits);
		end
	end
endmodule

// *** rtl/eirq_avs.sv ***
// Avalon-MM slave front end with one wait cycle
`timescale 1ns/10ps
module eirq_avs (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] rd_data,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic wr_stb
);
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic wait_reg;
	logic wait_next;

	// ==========================================
	// Answer one cycle after the request
	always_comb begin
		ack_next = (avs_read || avs_write) && !ack_reg;
		wait_next = !ack_next;
		rdata_next = rdata_reg;
		if (avs_read && !ack_reg) begin
			rdata_next = rd_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ack_reg <= 1'b0;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= ack_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign wr_stb = ack_reg && avs_write;

	AST_BUS_ONE_WAIT: assert property (@(posedge mclk) disable iff (!rstn)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
endmodule

// *** verif/eirq_dev_model.sv ***
// Behavioural model of the endpoint interrupt port
`timescale 1ns/10ps
module eirq_dev_model #(
	parameter logic [15:0] MSG_DATA = 16'h4100
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic irq_req,
	input wire logic irq_assert_sel,
	input wire logic [7:0] irq_vector_in,
	input wire logic msi_mode,
	input wire logic intr_disable,
	input wire logic [3:0] lat,
	input wire logic [31:0] msg_upper,
	output logic irq_accept,
	output logic [7:0] n_raise,
	output logic [7:0] n_drop,
	output logic [7:0] n_msi,
	output logic [7:0] n_late,
	output logic [7:0] last_vec,
	output logic last_wide,
	output logic [15:0] last_data
);
	logic [3:0] wait_cnt;
	logic armed;
	logic after;
	// ==========================================
	// Accept and message recording
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			irq_accept <= 1'b0;
			n_raise <= 8'h00;
			n_drop <= 8'h00;
			n_msi <= 8'h00;
			n_late <= 8'h00;
			last_vec <= 8'h00;
			last_wide <= 1'b0;
			last_data <= 16'h0000;
			wait_cnt <= 4'h0;
			armed <= 1'b0;
			after <= 1'b0;
		end else begin
			irq_accept <= 1'b0;
			after <= irq_accept;
			if (irq_accept) begin
				armed <= 1'b0;
			end
			if (after && irq_req) begin
				n_late <= n_late + 8'h01;
			end
			if (!irq_req) begin
				armed <= 1'b1;
				wait_cnt <= 4'h0;
			end else if (armed && !irq_accept) begin
				if (wait_cnt >= lat) begin
					irq_accept <= 1'b1;
					wait_cnt <= 4'h0;
					last_vec <= irq_vector_in;
					if (msi_mode) begin
						n_msi <= n_msi + 8'h01;
						last_wide <= (msg_upper != 32'h0000_0000);
						last_data <= MSG_DATA | {8'h00, irq_vector_in};
					end else if (!irq_assert_sel) begin
						n_drop <= n_drop + 8'h01;
					end else if (!intr_disable) begin
						n_raise <= n_raise + 8'h01;
					end
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule

// *** verif/eirq_ctrl_bench.sv ***
// Testbench of the interrupt request controller
`timescale 1ns/10ps
module eirq_ctrl_bench;
	logic mclk;
	logic rstn;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq_req;
	logic irq_assert_sel;
	logic [7:0] irq_vector_in;
	logic irq_accept;
	logic msi_mode;
	logic msix_mode;
	logic [2:0] mm_enable;
	logic intr_disable;
	logic [3:0] lat;
	logic [7:0] n_raise;
	logic [7:0] n_drop;
	logic [7:0] n_msi;
	logic [7:0] n_late;
	logic [7:0] last_vec;
	logic [31:0] msg_upper;
	logic last_wide;
	logic [15:0] last_data;
	localparam logic [15:0] MSG_WORD = 16'h4100;
	logic [31:0] q;
	int n_fail;
	int checked;
	int b;

	eirq_ctrl dut_u (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq_req(irq_req), .irq_assert_sel(irq_assert_sel),
		.irq_vector_in(irq_vector_in), .irq_accept(irq_accept),
		.msi_mode(msi_mode), .msix_mode(msix_mode), .mm_enable(mm_enable),
		.intr_disable(intr_disable));
	eirq_dev_model #(.MSG_DATA(MSG_WORD)) dev_u (.mclk(mclk), .rstn(rstn),
		.irq_req(irq_req),
		.irq_assert_sel(irq_assert_sel), .irq_vector_in(irq_vector_in),
		.msi_mode(msi_mode), .intr_disable(intr_disable), .lat(lat),
		.irq_accept(irq_accept), .n_raise(n_raise), .n_drop(n_drop),
		.n_msi(n_msi), .n_late(n_late), .last_vec(last_vec),
		.msg_upper(msg_upper), .last_wide(last_wide), .last_data(last_data));

	always #12.5 mclk = ~mclk;

	// ==========================================
	// Tasks
	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int i;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && i < 40) begin
			@(posedge mclk);
			i++;
		end
		q = avs_readdata;
		if (i >= 40) begin
			n_fail++;
			end_of_test();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic cmd(input logic [8:0] v);
		int i;
		bus(1'b1, eirq_pkg::CMD_OFS, 32'(v));
		i = 0;
		while (irq_req !== 1'b0 && i < 60) begin
			@(posedge mclk);
			i++;
		end
		if (i >= 60) begin
			n_fail++;
			end_of_test();
		end
		repeat (2) @(posedge mclk);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		msi_mode = 1'b0;
		msix_mode = 1'b0;
		mm_enable = 3'h0;
		intr_disable = 1'b0;
		lat = 4'h0;
		msg_upper = 32'h0000_0000;
		n_fail = 0;
		checked = 0;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		chk("irq_req", 32'h0, 32'(irq_req));
		bus(1'b0, eirq_pkg::COUNT_OFS, 32'h0);
		chk("count", 32'(eirq_pkg::COUNT_RESET), q);
		bus(1'b0, eirq_pkg::MASK_OFS, 32'h0);
		chk("mask", eirq_pkg::MASK_RESET, q);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, q);
		lat <= 4'h3;
		cmd({1'b1, 8'h5A});
		chk("raise", 32'h1, 32'(n_raise));
		chk("vec", 32'(eirq_pkg::LINE_A_VEC), 32'(last_vec));
		bus(1'b0, eirq_pkg::STATUS_OFS, 32'h0);
		chk("raised", 32'h1, 32'(q[eirq_pkg::ST_RAISED_BIT]));
		cmd({1'b0, 8'h00});
		chk("drop", 32'h1, 32'(n_drop));
		bus(1'b0, eirq_pkg::STATUS_OFS, 32'h0);
		chk("raised", 32'h0, 32'(q[eirq_pkg::ST_RAISED_BIT]));
		intr_disable <= 1'b1;
		cmd({1'b1, 8'h00});
		chk("blocked", 32'h1, 32'(n_raise));
		bus(1'b0, eirq_pkg::STATUS_OFS, 32'h0);
		chk("intdis", 32'h1, 32'(q[eirq_pkg::ST_INTDIS_BIT]));
		cmd({1'b0, 8'h00});
		intr_disable <= 1'b0;
		msi_mode <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			mm_enable <= 3'(m);
			lat <= 4'(m);
			msg_upper <= (m > 3) ? 32'h0000_0001 : 32'h0000_0000;
			cmd({1'b0, 8'hFF});
			b = (m > 5) ? 5 : m;
			chk("msi_vec", 32'((1 << b) - 1), 32'(last_vec));
			chk("msi_wide", 32'(m > 3), 32'(last_wide));
			chk("msi_data", 32'(MSG_WORD | 16'((1 << b) - 1)), 32'(last_data));
		end
		chk("msi_n", 32'h8, 32'(n_msi));
		chk("late", 32'h0, 32'(n_late));
		bus(1'b0, eirq_pkg::STATUS_OFS, 32'h0);
		chk("mmen", 32'h7, 32'(q[eirq_pkg::ST_MMEN_LSB +: 3]));
		chk("msi", 32'h1, 32'(q[eirq_pkg::ST_MSI_BIT]));
		mm_enable <= 3'h5;
		bus(1'b1, eirq_pkg::MASK_OFS, 32'h0000_0008);
		cmd({1'b0, 8'h03});
		chk("masked", 32'h8, 32'(n_msi));
		bus(1'b0, eirq_pkg::STATUS_OFS, 32'h0);
		chk("refused", 32'h1, 32'(q[eirq_pkg::ST_REFUSED_BIT]));
		bus(1'b1, eirq_pkg::STATUS_OFS, 32'h0000_0004);
		bus(1'b0, eirq_pkg::STATUS_OFS, 32'h0);
		chk("refused", 32'h0, 32'(q[eirq_pkg::ST_REFUSED_BIT]));
		cmd({1'b0, 8'h04});
		chk("unmasked", 32'h04, 32'(last_vec));
		msix_mode <= 1'b1;
		cmd({1'b0, 8'h01});
		chk("msix", 32'h9, 32'(n_msi));
		msix_mode <= 1'b0;
		lat <= 4'hF;
		bus(1'b1, eirq_pkg::CMD_OFS, 32'h0000_0001);
		cmd({1'b0, 8'h02});
		chk("busy", 32'hA, 32'(n_msi));
		chk("busy_vec", 32'h01, 32'(last_vec));
		bus(1'b0, eirq_pkg::COUNT_OFS, 32'h0);
		chk("count", 32'd14, q);
		bus(1'b0, eirq_pkg::CMD_OFS, 32'h0);
		chk("cmd_rb", 32'h0000_0001, q);
		end_of_test();
	end
endmodule
